/* verilog/arb_mask_pkg.sv */
// Package: register map, field positions, reset values and timing for the secondary bus arbiter
package arb_mask_pkg;
    localparam int NUM_LINES = 6;
    localparam logic [7:0] MASK_CTRL_OFFSET = 8'hDD;
    localparam logic [7:0] EXPIRED_OFFSET = 8'hDE;
    localparam logic [7:0] CLOCK_CTRL_OFFSET = 8'hDC;
    localparam logic [7:0] MASK_CTRL_RESET = 8'h00;
    localparam logic [7:0] EXPIRED_RESET = 8'h00;
    localparam logic [7:0] CLOCK_CTRL_RESET = 8'h40;
    localparam int LIMIT_ENABLE_BIT = 7;
    localparam int AUTO_IGNORE_BIT = 6;
    localparam int PARK_BRIDGE_BIT = 7;
    localparam int BRIDGE_LEVEL_BIT = 6;
    localparam logic [1:0] EXPIRED_RSVD = 2'h0;
    localparam int IDLE_LIMIT_CLOCKS = 16;
    localparam logic [4:0] IDLE_LIMIT_COUNT = 5'(IDLE_LIMIT_CLOCKS);
    // Grant index 6 stands for the bridge itself
    localparam logic [2:0] BRIDGE_ID = 3'h6;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_BUSY = 3'b100
    } arb_state_t;
endpackage : arb_mask_pkg

/* verilog/arb_pick.sv */
// Module: two-tier round-robin selection among masked requests
`timescale 1ns/1ps
module arb_pick
    import arb_mask_pkg::*;
#(
    parameter int N = 7
)
(
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] high_tier,
    input wire logic [2:0] last,
    output logic found,
    output logic [2:0] winner
);
    logic [N-1:0] hi_req;
    logic [N-1:0] use_req;
    int idx;

    assign hi_req = req & high_tier;
    assign use_req = (|hi_req) ? hi_req : req;

    // Rotating search starting after the last winner
    always_comb
    begin
        found = 1'b0;
        winner = 3'h0;
        idx = 0;
        for (int k = 1; k <= N; k++)
        begin
            idx = (int'(last) + k) % N;
            if (!found && use_req[idx])
            begin
                found = 1'b1;
                winner = 3'(idx);
            end
        end
    end
endmodule : arb_pick

/* verilog/sec_bus_arbiter.sv */
// Module: secondary bus arbiter with request masking, idle-grant time-out and sticky expiry flags
`timescale 1ns/1ps
// Summary of operation
// (RQ1) With limit enabled, count clocks from bus idle; expire after 16 without frame
// (RQ2) With limit disabled, never expire; wait for granted master indefinitely
// (RQ3) With auto-ignore set, an expiry sets that line's ignore bit
// (RQ4) A set ignore bit removes its request line from arbitration
// (RQ5) Mask and limit control register resets to zero
// (RQ6) An expiry sets the flag of the granted line
// (RQ7) Flags read one after an expiry, zero otherwise and after reset
// (RQ8) Flag register bits 7:6 read zero
// (RQ9) Granted master must start frame within the limit after bus idle
// (RQ10) Idle bus parks on last master, or on the bridge when park bit set
// (RQ11) Two priority tiers; bridge high by default, masters low
// (RQ12) Ignore bit n and flag bit n both belong to request line n
// (RQ13) Flags stay set until a one is written to them
module sec_bus_arbiter
    import arb_mask_pkg::*;
#(
    parameter int LINES = NUM_LINES
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [LINES-1:0] req_n,
    input wire logic bridge_req,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic [LINES-1:0] gnt_n,
    output logic bridge_gnt
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] mask_ctrl_q;
    logic [7:0] clock_ctrl_q;
    logic [LINES-1:0] expired_q;
    arb_state_t state_q;
    logic [2:0] owner_q;
    logic [2:0] last_q;
    logic [4:0] idle_cnt_q;
    logic bus_idle;
    logic expire;
    logic [LINES:0] eligible;
    logic [LINES:0] tier;
    logic found;
    logic [2:0] winner;
    logic [LINES-1:0] auto_set;
    logic [LINES-1:0] flag_set;

    assign bus_idle = frame_n && irdy_n;
    // Ignore bits gate each request line
    assign eligible = {bridge_req, ~req_n & ~mask_ctrl_q[LINES-1:0]}; // RQ4 RQ12
    assign tier = {clock_ctrl_q[BRIDGE_LEVEL_BIT], clock_ctrl_q[LINES-1:0]}; // RQ11

    arb_pick #(.N(LINES + 1)) u_pick (
        .req(eligible),
        .high_tier(tier),
        .last(last_q),
        .found(found),
        .winner(winner)
    );

    // Expiry only when enabled and the granted master idled past the limit
    assign expire = (state_q == ST_WAIT) && mask_ctrl_q[LIMIT_ENABLE_BIT] && owner_q != BRIDGE_ID
        && frame_n && (idle_cnt_q == IDLE_LIMIT_COUNT - 5'h1); // RQ1 RQ2

    generate
        for (genvar i = 0; i < LINES; i++)
        begin : g_line
            assign flag_set[i] = expire && owner_q == 3'(i); // RQ6 RQ12
            assign auto_set[i] = flag_set[i] && mask_ctrl_q[AUTO_IGNORE_BIT]; // RQ3
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            mask_ctrl_q <= MASK_CTRL_RESET; // RQ5
        end
        else
        begin
            if (cfg_wr && cfg_addr == MASK_CTRL_OFFSET)
            begin
                mask_ctrl_q <= cfg_wdata | {2'h0, auto_set};
            end
            else
            begin
                mask_ctrl_q <= mask_ctrl_q | {2'h0, auto_set}; // RQ3
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            clock_ctrl_q <= CLOCK_CTRL_RESET; // RQ11
        end
        else if (cfg_wr && cfg_addr == CLOCK_CTRL_OFFSET)
        begin
            clock_ctrl_q <= cfg_wdata;
        end
    end

    // Sticky flags, write one to clear, set wins over clear
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            expired_q <= EXPIRED_RESET[LINES-1:0]; // RQ7
        end
        else if (cfg_wr && cfg_addr == EXPIRED_OFFSET)
        begin
            expired_q <= (expired_q & ~cfg_wdata[LINES-1:0]) | flag_set; // RQ13
        end
        else
        begin
            expired_q <= expired_q | flag_set; // RQ7
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            cfg_rdata <= 8'h00;
        end
        else if (cfg_rd)
        begin
            case (cfg_addr)
                MASK_CTRL_OFFSET: cfg_rdata <= mask_ctrl_q;
                EXPIRED_OFFSET: cfg_rdata <= {EXPIRED_RSVD, expired_q}; // RQ8
                CLOCK_CTRL_OFFSET: cfg_rdata <= clock_ctrl_q;
                default: cfg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Grant sequencing
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            owner_q <= BRIDGE_ID;
            last_q <= BRIDGE_ID;
            idle_cnt_q <= 5'h0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    idle_cnt_q <= 5'h0;
                    if (found && bus_idle)
                    begin
                        owner_q <= winner;
                        state_q <= ST_WAIT;
                    end
                    else if (clock_ctrl_q[PARK_BRIDGE_BIT])
                    begin
                        owner_q <= BRIDGE_ID; // RQ10
                    end
                    else
                    begin
                        owner_q <= last_q; // RQ10
                    end
                end
                ST_WAIT:
                begin
                    if (!frame_n)
                    begin
                        last_q <= owner_q;
                        state_q <= ST_BUSY;
                    end
                    // A dropped or ignored request, the bridge's too, gives the bus back
                    else if (expire || !eligible[owner_q])
                    begin
                        state_q <= ST_IDLE; // RQ9
                    end
                    else if (bus_idle && mask_ctrl_q[LIMIT_ENABLE_BIT])
                    begin
                        idle_cnt_q <= idle_cnt_q + 5'h1; // RQ1
                    end
                end
                ST_BUSY:
                begin
                    if (bus_idle)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            gnt_n <= '1;
            bridge_gnt <= 1'b1;
        end
        else
        begin
            for (int i = 0; i < LINES; i++)
            begin
                gnt_n[i] <= !(state_q != ST_BUSY && owner_q == 3'(i));
            end
            bridge_gnt <= state_q != ST_BUSY && owner_q == BRIDGE_ID;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_flag_after_expire: assert property (@(posedge mclk) disable iff (!reset_n)
        expire |=> expired_q[$past(owner_q)]) else $error("expiry flag not set"); // RQ6
    a_no_expire_off: assert property (@(posedge mclk) disable iff (!reset_n)
        !mask_ctrl_q[LIMIT_ENABLE_BIT] |-> !expire) else $error("expiry while disabled"); // RQ2
    a_auto_ignore: assert property (@(posedge mclk) disable iff (!reset_n)
        expire && mask_ctrl_q[AUTO_IGNORE_BIT] |=> mask_ctrl_q[$past(owner_q)])
        else $error("auto ignore missing"); // RQ3
    a_no_auto: assert property (@(posedge mclk) disable iff (!reset_n)
        expire && !mask_ctrl_q[AUTO_IGNORE_BIT] && !cfg_wr |=> !$rose(mask_ctrl_q[LINES-1:0] != 6'h0))
        else $error("unexpected ignore"); // RQ3
    a_rsvd_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        cfg_rd && cfg_addr == EXPIRED_OFFSET |=> cfg_rdata[7:6] == 2'h0) else $error("reserved set"); // RQ8
    a_flag_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
        expired_q != 6'h0 && !cfg_wr |=> (expired_q & $past(expired_q)) == $past(expired_q))
        else $error("flag lost"); // RQ13
    a_masked_no_gnt: assert property (@(posedge mclk) disable iff (!reset_n)
        state_q == ST_IDLE && found |-> !(winner < 3'(LINES) && mask_ctrl_q[winner]))
        else $error("ignored line won"); // RQ4
    a_limit_count: assert property (@(posedge mclk) disable iff (!reset_n)
        expire |-> $past(state_q, 15) == ST_WAIT) else $error("bad limit"); // RQ1
endmodule : sec_bus_arbiter

/* tb/bus_master_model.sv */
// Model of the external masters on the secondary bus
`timescale 1ns/1ps
module bus_master_model (
    input wire logic mclk,
    input wire logic [5:0] want,
    input wire logic respond,
    input wire logic [5:0] gnt_n,
    output logic [5:0] req_n,
    output logic frame_n,
    output logic irdy_n
);
    logic [1:0] ph_q;
    initial
    begin
        ph_q = 2'h0;
        frame_n = 1'b1;
        irdy_n = 1'b1;
    end
    assign req_n = ~want;
    // Granted master starts a one-phase transfer on an idle bus
    always @(posedge mclk)
    begin
        case (ph_q)
            2'h0: if (respond && |(~gnt_n & want) && frame_n && irdy_n)
            begin
                frame_n <= 1'b0;
                irdy_n <= 1'b0;
                ph_q <= 2'h1;
            end
            2'h1:
            begin
                frame_n <= 1'b1;
                ph_q <= 2'h2;
            end
            default:
            begin
                irdy_n <= 1'b1;
                ph_q <= 2'h0;
            end
        endcase
    end
endmodule : bus_master_model

/* tb/test_sec_bus_arbiter.sv */
// Testbench for the secondary bus arbiter
`timescale 1ns/1ps
module test_sec_bus_arbiter import arb_mask_pkg::*;;
    logic mclk = 0, reset_n = 0, respond = 0, frame_n, irdy_n;
    logic cfg_wr = 0, cfg_rd = 0, bridge_req = 0, bridge_gnt;
    logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
    logic [5:0] want = 6'h00, req_n, gnt_n, seen;
    int err_total = 0, tests_run = 0;
    sec_bus_arbiter sec_bus_arbiter_inst (.mclk(mclk), .reset_n(reset_n), .req_n(req_n),
        .bridge_req(bridge_req), .frame_n(frame_n), .irdy_n(irdy_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .gnt_n(gnt_n),
        .bridge_gnt(bridge_gnt));
    bus_master_model bus_master_model_inst (.mclk(mclk), .want(want), .respond(respond),
        .gnt_n(gnt_n), .req_n(req_n), .frame_n(frame_n), .irdy_n(irdy_n));
    initial
    begin
        forever #4 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
        @(negedge mclk);
        cfg_wr = 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(negedge mclk);
        cfg_rd = 1'b0;
        @(negedge mclk);
        check(cfg_rdata, exp);
    endtask : rd_chk
    task automatic wait_gnt(input int i);
        int n;
        for (n = 0; n < 20 && gnt_n[i] !== 1'b0; n++)
            @(negedge mclk);
        check({7'h0, gnt_n[i]}, 8'h00);
    endtask : wait_gnt
    task automatic idle_ok(input int cyc, input logic [5:0] bad);
        seen = 6'h00;
        repeat (cyc) @(negedge mclk) seen |= ~gnt_n & bad;
        check({2'h0, seen}, 8'h00);
    endtask : idle_ok
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check({1'b0, bridge_gnt, gnt_n}, 8'h7F);
        rd_chk(MASK_CTRL_OFFSET, 8'h00);
        rd_chk(EXPIRED_OFFSET, 8'h00);
        rd_chk(CLOCK_CTRL_OFFSET, 8'h40);
        wr(EXPIRED_OFFSET, 8'hFF);
        rd_chk(EXPIRED_OFFSET, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_mask;
        wr(MASK_CTRL_OFFSET, 8'h08);
        want = 6'h08;
        idle_ok(30, 6'h08);
        want = 6'h0C;
        wait_gnt(2);
        idle_ok(40, 6'h3B);
        check({7'h0, gnt_n[2]}, 8'h00);
        rd_chk(EXPIRED_OFFSET, 8'h00);
        want = 6'h00;
        wr(MASK_CTRL_OFFSET, 8'h00);
        $display("t_mask done");
    endtask : t_mask
    task automatic t_expire;
        wr(MASK_CTRL_OFFSET, 8'h80);
        want = 6'h10;
        wait_gnt(4);
        repeat (13) @(negedge mclk);
        check({7'h0, gnt_n[4]}, 8'h00);
        // Flag must still read clear when sampled at the edge that ends the sixteenth idle clock
        rd_chk(EXPIRED_OFFSET, 8'h00);
        want = 6'h00;
        rd_chk(EXPIRED_OFFSET, 8'h10);
        wr(EXPIRED_OFFSET, 8'h00);
        rd_chk(EXPIRED_OFFSET, 8'h10);
        wr(EXPIRED_OFFSET, 8'h10);
        rd_chk(EXPIRED_OFFSET, 8'h00);
        rd_chk(MASK_CTRL_OFFSET, 8'h80);
        check({1'b0, bridge_gnt, gnt_n}, 8'h7F);
        $display("t_expire done");
    endtask : t_expire
    task automatic t_auto;
        wr(MASK_CTRL_OFFSET, 8'hC0);
        want = 6'h02;
        wait_gnt(1);
        repeat (22) @(negedge mclk);
        rd_chk(MASK_CTRL_OFFSET, 8'hC2);
        rd_chk(EXPIRED_OFFSET, 8'h02);
        idle_ok(30, 6'h02);
        want = 6'h00;
        wr(MASK_CTRL_OFFSET, 8'h80);
        wr(EXPIRED_OFFSET, 8'h3F);
        $display("t_auto done");
    endtask : t_auto
    task automatic t_respond;
        respond = 1'b1;
        want = 6'h01;
        wait_gnt(0);
        repeat (80) @(negedge mclk);
        want = 6'h00;
        respond = 1'b0;
        rd_chk(EXPIRED_OFFSET, 8'h00);
        $display("t_respond done");
    endtask : t_respond
    task automatic t_tier;
        wr(CLOCK_CTRL_OFFSET, 8'hE0);
        rd_chk(CLOCK_CTRL_OFFSET, 8'hE0);
        want = 6'h22;
        wait_gnt(5);
        check({7'h0, gnt_n[1]}, 8'h01);
        want = 6'h00;
        repeat (3) @(negedge mclk);
        check({1'b0, bridge_gnt, gnt_n}, 8'h7F);
        // High-tier bridge holds off a low-tier line until it lets go
        bridge_req = 1'b1;
        want = 6'h02;
        idle_ok(20, 6'h02);
        bridge_req = 1'b0;
        wait_gnt(1);
        want = 6'h00;
        wr(CLOCK_CTRL_OFFSET, 8'h40);
        repeat (2) @(negedge mclk);
        check({1'b0, bridge_gnt, gnt_n}, 8'h3E);
        $display("t_tier done");
    endtask : t_tier
    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    initial
    begin
        #200000;
        err_total++;
        results();
    end
    initial
    begin
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        @(negedge mclk);
        t_reset();
        t_mask();
        t_expire();
        t_auto();
        t_respond();
        t_tier();
        results();
    end
endmodule : test_sec_bus_arbiter
